/* src/jesd_link_config_map.svh */
`ifndef JESD_LINK_CONFIG_MAP_SVH
`define JESD_LINK_CONFIG_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_LINK_CFG    8'h00
`define ADDR_IDENT       8'h04
`define ADDR_LANE_OVR_EN 8'h08
`define ADDR_LID_LO      8'h0c
`define ADDR_LID_HI      8'h10
`define ADDR_SUM_LO      8'h14
`define ADDR_SUM_HI      8'h18
`define ADDR_PARAM_STAT  8'h20
`define ADDR_LANE_STAT   8'h24
`define ADDR_LANE_BASE   8'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_CPL_LSB      0
`define CFG_RES_LSB      2
`define CFG_SER_LSB      4
`define CFG_OPO_BIT      6
`define CFG_SCR_BIT      7
`define CFG_VOVR_BIT     8
`define CFG_VER_LSB      9
`define CFG_SUB_LSB      12
`define CFG_KFRC_BIT     15
`define CFG_KVAL_LSB     16
`define IDENT_BID_LSB    0
`define IDENT_DID_LSB    8
`define OVR_LID_LSB      0
`define OVR_SUM_LSB      8

// ****************************************************************
// Codes, reset values and write masks
// ****************************************************************
`define CPL_EIGHT        2'h0
`define CPL_FOUR         2'h1
`define CPL_TWO          2'h2
`define RST_LINK_CFG     32'h0000_0015
`define RST_ZERO         32'h0000_0000
`define MSK_LINK_CFG     32'h001f_ffff
`define MSK_IDENT        32'h0000_ff0f
`define MSK_LANE_OVR_EN  32'h0000_ffff
`define MSK_LID          32'h1f1f_1f1f
`define MSK_SUM          32'hffff_ffff
`define K_DEFAULT        5'h03
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* src/jesd_link_config_pkg.sv */
package jesd_link_config_pkg;

  typedef logic [7:0][4:0]  lid_arr_t;
  typedef logic [7:0][7:0]  sum_arr_t;
  typedef logic [7:0][15:0] word_arr_t;
  typedef logic [6:0][31:0] ctl_arr_t;

  typedef struct packed {
    ctl_arr_t    ctl;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  did;
    logic [3:0]  bid;
    lid_arr_t    lid;
    logic [4:0]  l;
    logic [7:0]  f;
    logic [4:0]  k;
    logic [7:0]  m;
    logic [4:0]  n;
    logic [4:0]  nprime;
    logic [4:0]  s;
    logic        scr;
    logic [4:0]  cf;
    logic [2:0]  jesdv;
    logic [2:0]  subclassv;
    logic        phadj;
    logic [7:0]  res1;
    logic [7:0]  res2;
    sum_arr_t    fchk;
    logic [7:0]  pd;
    logic [2:0]  cnt;
    word_arr_t   word;
    logic        lane_valid;
    logic        frame_start;
  } state_s;

endpackage : jesd_link_config_pkg

/* src/jesd_link_config_transport.sv */
// Operation
// R01 - K field is K-1, default 3, forceable
// R02 - Lanes 2/4/8, field L-1, default 4
// R03 - Lane_ident_override_val 1..8, per-lane override
// R04 - M fixed 16, S fixed 1, minus one
// R05 - N from resolution select, minus one
// R06 - N' derived from mode, minus one
// R07 - SCR mirrors scramble enable, default off
// R08 - PHADJ and both reserved fields zero
// R09 - No control words: CF zero
// R10 - Per-lane checksum, per-lane override
// R11 - Version A code 000, B 001
// R12 - Override off: B subclass 1 forced
// R13 - Override on: version/subclass from settings
// R14 - Converters mapped to lanes by mode
// R15 - Unused lanes powered down
// R16 - Packing mode bit: normal or per-octet
// R17 - Converters per lane sets lane count
// R18 - Samples framed per lane, tail zeros
// R19 - F field is F-1, default 6
// R20 - Bank_ident_setting from setting, default 0
// R21 - Dev_ident_setting from setting, default 0
// R22 - Software keeps serialization >= resolution
// R23 - Software changes config only when idle
`timescale 1ns/1ps
`include "jesd_link_config_map.svh"

module jesd_link_config_transport (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [7:0]                     awaddr,
  input  wire logic                           awvalid,
  output wire logic                           awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output wire logic                           wready,
  output wire logic [1:0]                     bresp,
  output wire logic                           bvalid,
  input  wire logic                           bready,
  input  wire logic [7:0]                     araddr,
  input  wire logic                           arvalid,
  output wire logic                           arready,
  output wire logic [31:0]                    rdata,
  output wire logic [1:0]                     rresp,
  output wire logic                           rvalid,
  input  wire logic                           rready,
  input  wire logic [15:0][15:0]              conv_sample,
  input  wire logic                           sample_valid,
  output wire logic [7:0]                     ilas_did,
  output wire logic [3:0]                     ilas_bid,
  output wire jesd_link_config_pkg::lid_arr_t ilas_lid,
  output wire logic [4:0]                     ilas_l,
  output wire logic [7:0]                     ilas_f,
  output wire logic [4:0]                     ilas_k,
  output wire logic [7:0]                     ilas_m,
  output wire logic [4:0]                     ilas_n,
  output wire logic [4:0]                     ilas_nprime,
  output wire logic [4:0]                     ilas_s,
  output wire logic                           ilas_scr,
  output wire logic [4:0]                     ilas_cf,
  output wire logic [2:0]                     ilas_jesdv,
  output wire logic [2:0]                     ilas_subclassv,
  output wire logic                           ilas_phadj,
  output wire logic [7:0]                     ilas_res1,
  output wire logic [7:0]                     ilas_res2,
  output wire jesd_link_config_pkg::sum_arr_t ilas_fchk,
  output wire logic [7:0]                     lane_powerdown,
  output wire jesd_link_config_pkg::word_arr_t lane_word,
  output wire logic                           lane_valid,
  output wire logic                           frame_start
);

  // ****************************************************************
  // Register reset values and write masks
  // ****************************************************************
  localparam jesd_link_config_pkg::ctl_arr_t CTL_RST = {
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_LINK_CFG};
  localparam jesd_link_config_pkg::ctl_arr_t CTL_MSK = {
    `MSK_SUM, `MSK_SUM, `MSK_LID, `MSK_LID, `MSK_LANE_OVR_EN, `MSK_IDENT, `MSK_LINK_CFG};

  jesd_link_config_pkg::state_s state_r;
  jesd_link_config_pkg::state_s state_nxt;

  // ****************************************************************
  // Settings decoded from the control words
  // ****************************************************************
  logic [31:0] cfg_w;
  logic [1:0]  cpl_code;
  logic        opo;
  logic [4:0]  res_bits;
  logic [4:0]  ser_bits;
  logic [4:0]  l_val;
  logic [7:0]  f_val;
  logic [4:0]  np_val;
  logic [4:0]  k_val;
  logic [2:0]  cpl_last;
  logic [7:0]  pd_val;
  logic [2:0]  ver_val;
  logic [2:0]  sub_val;
  logic [7:0]  base_sum;
  logic [4:0]  shift;

  assign cfg_w    = state_r.ctl[0];
  assign cpl_code = cfg_w[`CFG_CPL_LSB +: 2];
  assign opo      = cfg_w[`CFG_OPO_BIT]; // R16
  assign res_bits = 5'd10 + {2'h0, cfg_w[`CFG_RES_LSB +: 2], 1'b0}; // R05
  assign ser_bits = 5'd10 + {2'h0, cfg_w[`CFG_SER_LSB +: 2], 1'b0};
  assign shift    = 5'd16 - res_bits;
  assign k_val    = cfg_w[`CFG_KFRC_BIT] ? cfg_w[`CFG_KVAL_LSB +: 5] : `K_DEFAULT; // R01

  always_comb begin
    case (cpl_code)
      `CPL_EIGHT: begin // R17
        l_val    = 5'd2;
        cpl_last = 3'd7;
        pd_val   = 8'hee; // R15
        np_val   = opo ? 5'd16 : ser_bits; // R06
        f_val    = opo ? 8'd16 : {3'h0, ser_bits}; // R19
      end
      `CPL_TWO: begin // R17
        l_val    = 5'd8;
        cpl_last = 3'd1;
        pd_val   = 8'h00; // R15
        np_val   = (opo || ser_bits > 5'd12) ? 5'd16 : 5'd12; // R06
        f_val    = (opo || ser_bits > 5'd12) ? 8'd4 : 8'd3; // R19
      end
      default: begin // R17
        l_val    = 5'd4;
        cpl_last = 3'd3;
        pd_val   = 8'haa; // R15
        np_val   = opo ? 5'd16 : ser_bits; // R06
        f_val    = opo ? 8'd8 : {4'h0, ser_bits[4:1]}; // R19
      end
    endcase
  end

  // Override off forces B subclass 1, otherwise settings pass through
  assign ver_val = cfg_w[`CFG_VOVR_BIT] ? cfg_w[`CFG_VER_LSB +: 3] : 3'h1; // R11 R12 R13
  assign sub_val = cfg_w[`CFG_VOVR_BIT] ? cfg_w[`CFG_SUB_LSB +: 3] : 3'h1; // R12 R13

  // Sum of every lane-independent field, as sent
  assign base_sum = state_r.ctl[1][`IDENT_DID_LSB +: 8] + {4'h0, state_r.ctl[1][3:0]}
                  + {3'h0, l_val - 5'd1} + {7'h0, cfg_w[`CFG_SCR_BIT]} + (f_val - 8'd1)
                  + {3'h0, k_val - 5'd1} + 8'd15 + {3'h0, res_bits - 5'd1}
                  + {5'h0, sub_val} + {3'h0, np_val - 5'd1} + {5'h0, ver_val}; // R10

  // ****************************************************************
  // Per-lane identity, checksum and sample selection
  // ****************************************************************
  jesd_link_config_pkg::lid_arr_t  lid_c;
  jesd_link_config_pkg::sum_arr_t  sum_c;
  jesd_link_config_pkg::word_arr_t word_c;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lane
      logic [4:0] conv_idx;
      logic [7:0] lid_byte;
      logic [7:0] sum_byte;
      assign lid_byte = state_r.ctl[3 + gi / 4][(gi % 4) * 8 +: 8];
      assign sum_byte = state_r.ctl[5 + gi / 4][(gi % 4) * 8 +: 8];
      assign lid_c[gi] = state_r.ctl[2][`OVR_LID_LSB + gi] ?
                         lid_byte[4:0] : 5'(gi + 1); // R03
      assign sum_c[gi] = state_r.ctl[2][`OVR_SUM_LSB + gi] ?
                         sum_byte : base_sum + {3'h0, lid_c[gi]}; // R10
      // Each lane starts at converter 2*lane, stepping through its set
      assign conv_idx  = 5'(2 * gi) + {2'h0, state_r.cnt}; // R14
      assign word_c[gi] = pd_val[gi] ? 16'h0000 :
                          16'(conv_sample[conv_idx[3:0]] << shift); // R18
    end
  endgenerate

  // ****************************************************************
  // Register bus and next state
  // ****************************************************************
  always_comb begin
    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic [2:0] widx;
    logic [2:0] ridx;
    aw_fire   = awvalid && state_r.awready;
    w_fire    = wvalid && state_r.wready;
    ar_fire   = arvalid && state_r.arready;
    widx      = 3'h0;
    ridx      = araddr[4:2];
    state_nxt = state_r;

    if (state_r.bvalid && bready) begin
      state_nxt.bvalid = 1'b0;
    end
    if (aw_fire) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.awaddr  = awaddr;
    end
    if (w_fire) begin
      state_nxt.w_held = 1'b1;
      state_nxt.wdata  = wdata;
      state_nxt.wstrb  = wstrb;
    end
    if (state_nxt.aw_held && state_nxt.w_held) begin
      widx                = state_nxt.awaddr[4:2];
      state_nxt.aw_held   = 1'b0;
      state_nxt.w_held    = 1'b0;
      state_nxt.bvalid    = 1'b1;
      if (state_nxt.awaddr[7:5] == 3'h0 && state_nxt.awaddr[1:0] == 2'h0 && widx != 3'h7) begin
        for (int b = 0; b < 4; b++) begin
          if (state_nxt.wstrb[b]) begin
            state_nxt.ctl[widx][b * 8 +: 8] = state_nxt.wdata[b * 8 +: 8];
          end
        end
        state_nxt.ctl[widx] = state_nxt.ctl[widx] & CTL_MSK[widx];
        state_nxt.bresp     = `RESP_OKAY;
      end else begin
        state_nxt.bresp = `RESP_SLVERR;
      end
    end
    state_nxt.awready = !state_nxt.aw_held && !state_nxt.bvalid;
    state_nxt.wready  = !state_nxt.w_held && !state_nxt.bvalid;

    if (state_r.rvalid && rready) begin
      state_nxt.rvalid  = 1'b0;
      state_nxt.arready = 1'b1;
    end
    if (ar_fire) begin
      state_nxt.rvalid  = 1'b1;
      state_nxt.arready = 1'b0;
      state_nxt.rresp   = `RESP_OKAY;
      state_nxt.rdata   = 32'h0000_0000;
      if (araddr[1:0] != 2'h0) begin
        state_nxt.rresp = `RESP_SLVERR;
      end else if (araddr[7:5] == 3'h0 && ridx != 3'h7) begin
        state_nxt.rdata = state_r.ctl[ridx];
      end else if (araddr == `ADDR_PARAM_STAT) begin
        state_nxt.rdata = {3'h0, state_r.nprime, 3'h0, state_r.n,
                           3'h0, state_r.k, 3'h0, state_r.l};
      end else if (araddr == `ADDR_LANE_STAT) begin
        state_nxt.rdata = {7'h0, state_r.scr, 1'b0, state_r.subclassv, 1'b0,
                           state_r.jesdv, state_r.pd, state_r.f};
      end else if (araddr[7:5] == 3'h2) begin
        state_nxt.rdata = {16'h0000, state_r.fchk[ridx], 3'h0, state_r.lid[ridx]};
      end else begin
        state_nxt.rresp = `RESP_SLVERR;
      end
    end

    // Link parameters, each sent as the encoded field
    state_nxt.did       = state_r.ctl[1][`IDENT_DID_LSB +: 8]; // R21
    state_nxt.bid       = state_r.ctl[1][`IDENT_BID_LSB +: 4]; // R20
    state_nxt.lid       = lid_c; // R03
    state_nxt.l         = l_val - 5'd1; // R02
    state_nxt.f         = f_val - 8'd1; // R19
    state_nxt.k         = k_val - 5'd1; // R01
    state_nxt.m         = 8'd15; // R04
    state_nxt.n         = res_bits - 5'd1; // R05
    state_nxt.nprime    = np_val - 5'd1; // R06
    state_nxt.s         = 5'd0; // R04
    state_nxt.scr       = cfg_w[`CFG_SCR_BIT]; // R07
    state_nxt.cf        = 5'd0; // R09
    state_nxt.jesdv     = ver_val; // R11
    state_nxt.subclassv = sub_val; // R13
    state_nxt.phadj     = 1'b0; // R08
    state_nxt.res1      = 8'h00; // R08
    state_nxt.res2      = 8'h00; // R08
    state_nxt.fchk      = sum_c; // R10
    state_nxt.pd        = pd_val; // R15

    // One converter per valid cycle on each lane, frame wraps per set
    state_nxt.lane_valid  = sample_valid; // R18
    state_nxt.frame_start = sample_valid && state_r.cnt == 3'd0; // R18
    if (sample_valid) begin
      state_nxt.word = word_c; // R14
      state_nxt.cnt  = (state_r.cnt >= cpl_last) ? 3'd0 : state_r.cnt + 3'd1; // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r         <= '0;
      state_r.ctl     <= CTL_RST;
      state_r.awready <= 1'b1;
      state_r.wready  <= 1'b1;
      state_r.arready <= 1'b1;
      state_r.l       <= 5'd3;
      state_r.f       <= 8'd5;
      state_r.k       <= 5'd2;
      state_r.m       <= 8'd15;
      state_r.n       <= 5'd11;
      state_r.nprime  <= 5'd11;
      state_r.jesdv   <= 3'h1;
      state_r.subclassv <= 3'h1;
      state_r.pd      <= 8'haa;
      state_r.lid     <= {5'd8, 5'd7, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1};
      state_r.fchk    <= {8'h39, 8'h38, 8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready        = state_r.awready;
  assign wready         = state_r.wready;
  assign bvalid         = state_r.bvalid;
  assign bresp          = state_r.bresp;
  assign arready        = state_r.arready;
  assign rvalid         = state_r.rvalid;
  assign rdata          = state_r.rdata;
  assign rresp          = state_r.rresp;
  assign ilas_did       = state_r.did;
  assign ilas_bid       = state_r.bid;
  assign ilas_lid       = state_r.lid;
  assign ilas_l         = state_r.l;
  assign ilas_f         = state_r.f;
  assign ilas_k         = state_r.k;
  assign ilas_m         = state_r.m;
  assign ilas_n         = state_r.n;
  assign ilas_nprime    = state_r.nprime;
  assign ilas_s         = state_r.s;
  assign ilas_scr       = state_r.scr;
  assign ilas_cf        = state_r.cf;
  assign ilas_jesdv     = state_r.jesdv;
  assign ilas_subclassv = state_r.subclassv;
  assign ilas_phadj     = state_r.phadj;
  assign ilas_res1      = state_r.res1;
  assign ilas_res2      = state_r.res2;
  assign ilas_fchk      = state_r.fchk;
  assign lane_powerdown = state_r.pd;
  assign lane_word      = state_r.word;
  assign lane_valid     = state_r.lane_valid;
  assign frame_start    = state_r.frame_start;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready && awaddr == `ADDR_LINK_CFG && wstrb == 4'hf;
  endsequence
  sequence s_wr_answer;
    bvalid && bresp == `RESP_OKAY;
  endsequence

  a_cfg_write_lands: assert property (s_wr_taken |=> s_wr_answer ##1 // R07
      ilas_scr == $past(wdata[`CFG_SCR_BIT], 2))
    else $error("Link config write not answered or not applied");
  a_version_default: assert property (!cfg_w[`CFG_VOVR_BIT] |=> // R12
      ilas_jesdv == 3'h1 && ilas_subclassv == 3'h1)
    else $error("Version not forced to B subclass 1");
  a_version_from_set: assert property (cfg_w[`CFG_VOVR_BIT] |=> // R13
      ilas_subclassv == $past(cfg_w[`CFG_SUB_LSB +: 3]))
    else $error("Subclass not taken from setting");
  a_k_force_value: assert property (cfg_w[`CFG_KFRC_BIT] && // R01
      cfg_w[`CFG_KVAL_LSB +: 5] != 5'd0 |=> ilas_k == $past(cfg_w[`CFG_KVAL_LSB +: 5]) - 5'd1)
    else $error("Forced K not reported minus one");
  a_two_lane_mode: assert property (cpl_code == `CPL_EIGHT |=> // R02 R15
      ilas_l == 5'd1 && lane_powerdown == 8'hee)
    else $error("Two-lane mode lanes or power-down wrong");
  a_fixed_fields: assert property (ilas_m == 8'd15 && ilas_s == 5'd0 // R04 R08 R09
      && ilas_cf == 5'd0 && ilas_res1 == 8'h00 && ilas_res2 == 8'h00 && !ilas_phadj)
    else $error("Fixed link field not at its value");
  a_default_sum: assert property (cfg_w == `RST_LINK_CFG && state_r.ctl[1] == 32'h0 // R10
      && state_r.ctl[2] == 32'h0 |=> ilas_fchk[0] == 8'h32 && ilas_fchk[6] == 8'h38)
    else $error("Default lane checksum wrong");
  a_eight_lane_map: assert property (cpl_code == `CPL_TWO && // R14
      cfg_w[`CFG_RES_LSB +: 2] == 2'h1 && sample_valid && state_r.cnt == 3'd1 |=>
      lane_word[1] == 16'($past(conv_sample[3]) << 4))
    else $error("Eight-lane converter mapping wrong");
  a_frame_period: assert property (cpl_code == `CPL_TWO && sample_valid && // R18
      state_r.cnt == 3'd1 |=> frame_start == 1'b0 ##0 (state_r.cnt == 3'd0))
    else $error("Frame length in eight-lane mode wrong");

endmodule : jesd_link_config_transport

/* dv/link_rx_model.sv */
`timescale 1ns/1ps
// ******
// Receiver side: counts frame boundaries it is handed
// ******
module link_rx_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        lane_valid,
  input  wire logic        frame_start,
  output logic      [15:0] frames
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames <= 16'h0000;
    end else if (lane_valid && frame_start) begin
      frames <= frames + 16'h0001;
    end
  end
endmodule : link_rx_model

/* dv/tb.sv */
`timescale 1ns/1ps
`include "jesd_link_config_map.svh"
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r32;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, lane_valid, frame_start;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0][15:0] conv_sample;
  logic [7:0]  ilas_did, ilas_f, ilas_m, ilas_res1, ilas_res2, lane_powerdown;
  logic [3:0]  ilas_bid;
  logic [4:0]  ilas_l, ilas_k, ilas_n, ilas_nprime, ilas_s, ilas_cf;
  logic [2:0]  ilas_jesdv, ilas_subclassv;
  logic        ilas_scr, ilas_phadj;
  jesd_link_config_pkg::lid_arr_t  ilas_lid;
  jesd_link_config_pkg::sum_arr_t  ilas_fchk;
  jesd_link_config_pkg::word_arr_t lane_word;
  logic [15:0] frames;
  int          bad_count, checked, cycles;
  logic [31:0] seed;
  logic [1:0]  c_cpl, c_res, c_ser;
  logic        c_opo, c_scr, c_vo, c_kf;
  logic [2:0]  c_ver, c_sub;
  logic [4:0]  c_kv;
  logic [7:0]  c_did;
  logic [3:0]  c_bid;

  jesd_link_config_transport u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .conv_sample, .sample_valid, .ilas_did, .ilas_bid, .ilas_lid,
    .ilas_l, .ilas_f, .ilas_k, .ilas_m, .ilas_n, .ilas_nprime, .ilas_s, .ilas_scr, .ilas_cf,
    .ilas_jesdv, .ilas_subclassv, .ilas_phadj, .ilas_res1, .ilas_res2, .ilas_fchk,
    .lane_powerdown, .lane_word, .lane_valid, .frame_start);
  link_rx_model u_rx (.aclk, .aresetn, .lane_valid, .frame_start, .frames);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ******
  // Helpers
  // ******
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [4:0] el();
    return 5'((2 << c_cpl) - 1);
  endfunction : el
  function automatic logic [4:0] en();
    return 5'(9 + 2 * c_res);
  endfunction : en
  function automatic logic [4:0] ek();
    return c_kf ? 5'(c_kv - 5'h01) : 5'h02;
  endfunction : ek
  function automatic logic [7:0] ef();
    int sr;
    sr = 10 + 2 * c_ser;
    if (c_opo) return 8'((16 >> c_cpl) - 1);
    if (c_cpl == 2'h2) return (sr <= 12) ? 8'h02 : 8'h03;
    return 8'((sr >> c_cpl) - 1);
  endfunction : ef
  function automatic logic [4:0] enp();
    int sr;
    sr = 10 + 2 * c_ser;
    if (c_opo) return 5'h0f;
    if (c_cpl == 2'h2) return (sr <= 12) ? 5'h0b : 5'h0f;
    return 5'(sr - 1);
  endfunction : enp
  function automatic logic [7:0] epd();
    logic [7:0] p;
    p = 8'hff;
    for (int i = 0; i < 8; i++) if (i % (4 >> c_cpl) == 0) p[i] = 1'b0;
    return p;
  endfunction : epd
  function automatic logic [7:0] esum(input logic [4:0] lv);
    return 8'(c_did + c_bid + lv + el() + c_scr + ef() + ek() + 8'h0f + en()
      + (c_vo ? c_sub : 3'h1) + enp() + (c_vo ? c_ver : 3'h1));
  endfunction : esum

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready; tr = rvalid; r32 = rdata; resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : rd

  task automatic cfg_chk();
    chk(ilas_l, el());
    chk(ilas_f, ef());
    chk(ilas_n, en());
    chk(ilas_nprime, enp());
    chk(ilas_k, ek());
    chk(ilas_jesdv, c_vo ? c_ver : 3'h1);
    chk(ilas_subclassv, c_vo ? c_sub : 3'h1);
    chk(ilas_scr, c_scr);
    chk(lane_powerdown, epd());
    chk(ilas_fchk[0], esum(5'h01));
    rd(`ADDR_PARAM_STAT);
    chk(r32, {3'h0, enp(), 3'h0, en(), 3'h0, ek(), 3'h0, el()});
    rd(`ADDR_LANE_STAT);
    chk(r32, {7'h0, c_scr, 1'b0, (c_vo ? c_sub : 3'h1), 1'b0, (c_vo ? c_ver : 3'h1), epd(),
      ef()});
  endtask : cfg_chk

  task automatic put_cfg();
    logic [31:0] w;
    w = {11'h0, c_kv, c_kf, c_sub, c_ver, c_vo, c_scr, c_opo, c_ser, c_res, c_cpl};
    wr(`ADDR_LINK_CFG, w);
    chk(resp, `RESP_OKAY);
    if (c_cpl == 2'h3) c_cpl = 2'h1;
    @(negedge aclk);
    cfg_chk();
    rd(`ADDR_LINK_CFG);
    chk(r32, w);
  endtask : put_cfg

  task automatic xfer(input int steps);
    logic [15:0][15:0] nxt, prev;
    int cnt, cpn, f0;
    cnt = 0; cpn = 8 >> c_cpl; f0 = frames;
    for (int j = 0; j <= steps; j++) begin
      @(posedge aclk);
      for (int c = 0; c < 16; c++) nxt[c] = 16'(rnd()) & (16'hffff >> (6 - 2 * c_res));
      conv_sample <= nxt;
      sample_valid <= (j < steps);
      @(negedge aclk);
      if (j > 0) begin
        for (int i = 0; i < 8; i++)
          if (i % (cpn / 2) == 0) chk(lane_word[i], 16'(prev[2*i+cnt] << (6 - 2 * c_res)));
          else chk(lane_word[i], 16'h0000);
        chk(lane_valid, 1'b1);
        chk(frame_start, cnt == 0);
        cnt = (cnt + 1) % cpn;
      end
      prev = nxt;
    end
    @(negedge aclk);
    chk(lane_valid, 1'b0);
    chk(frames - f0, steps / cpn);
  endtask : xfer

  // ******
  // Main sequence
  // ******
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sample_valid} = '0;
    {awaddr, araddr, wdata, conv_sample} = '0;
    wstrb = 4'hf; aresetn = 1'b0; seed = 32'h0000_001b;
    bad_count = 0; checked = 0; cycles = 0;
    {c_opo, c_scr, c_vo, c_kf, c_ver, c_sub, c_kv, c_did, c_bid} = '0;
    c_cpl = 2'h1; c_res = 2'h1; c_ser = 2'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cfg_chk();
    chk({ilas_m, ilas_s, ilas_cf}, {8'h0f, 5'h00, 5'h00});
    chk({ilas_phadj, ilas_res1, ilas_res2}, 17'h0);
    for (int i = 0; i < 8; i++) chk({ilas_lid[i], ilas_fchk[i]}, {5'(i + 1), 8'(8'h32 + i)});
    rd(`ADDR_LINK_CFG);
    chk(r32, `RST_LINK_CFG);
    $display("defaults done");
    for (int t = 0; t < 5; t++) begin
      c_vo = (t < 4); c_ver = 3'(t != 0); c_sub = 3'(t == 0 ? 0 : t - 1);
      c_cpl = 2'(t == 4 ? 3 : 1);
      put_cfg();
    end
    $display("version table done");
    for (int t = 0; t < 12; t++) begin
      c_cpl = 2'(rnd() % 3); c_res = 2'(rnd()); c_opo = 1'(rnd()); c_scr = 1'(rnd());
      c_ser = 2'(c_res + rnd() % (4 - c_res));
      c_vo = 1'(rnd()); c_ver = 3'(rnd()); c_sub = 3'(rnd());
      c_kf = 1'(rnd()); c_kv = 5'(rnd() % 31 + 1);
      put_cfg();
    end
    $display("random configs done");
    foreach (seed[i]) if (i < 3) begin
      wr(i == 0 ? 8'h1c : (i == 1 ? `ADDR_PARAM_STAT : 8'h02), 32'hffff_ffff);
      chk(resp, `RESP_SLVERR);
      rd(i == 0 ? 8'h1c : 8'h03);
      chk({resp, r32}, {`RESP_SLVERR, 32'h0});
    end
    @(negedge aclk);
    cfg_chk();
    $display("refusals done");
    for (int md = 0; md < 3; md++) begin
      c_cpl = 2'(md); c_res = (md == 2) ? 2'h1 : 2'(rnd()); c_ser = 2'h3; c_opo = 1'b0;
      put_cfg();
      xfer(2 * (8 >> md));
    end
    $display("transport done");
    c_did = 8'(rnd()); c_bid = 4'(rnd());
    wr(`ADDR_IDENT, {16'h0, c_did, 4'h0, c_bid});
    wr(`ADDR_LANE_OVR_EN, 32'h0000_0201);
    wstrb <= 4'h1;
    wr(`ADDR_LID_LO, 32'hffff_ff07);
    wstrb <= 4'hf;
    wr(`ADDR_SUM_LO, 32'h0000_5a00);
    @(negedge aclk);
    chk({ilas_did, ilas_bid}, {c_did, c_bid});
    chk({ilas_lid[0], ilas_lid[1]}, {5'h07, 5'h02});
    chk({ilas_fchk[0], ilas_fchk[1]}, {esum(5'h07), 8'h5a});
    rd(8'(`ADDR_LANE_BASE + 8'h04));
    chk(r32, {16'h0, 8'h5a, 3'h0, 5'h02});
    $display("overrides done");
    tally_and_finish();
  end
endmodule : tb
